// ===== core/drtp_pin_edge.sv
/*
 * Pin synchroniser and edge detector.
 * Assumes rst_n is already synchronised.
 */
module drtp_pin_edge (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Synchronised reset, active low.
    input wire logic pin, // Raw pin level.
    input wire logic rise_sel, // High counts rising edges.
    output logic pulse // One cycle per selected edge.
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic pulse;
    } drtp_edge_type;
    drtp_edge_type st_r;
    drtp_edge_type st_nxt;

    // Only s2 reads s1, so a metastable first stage never reaches logic.
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.pulse = rise_sel ? (st_r.s2 & ~st_r.s3) : (~st_r.s2 & st_r.s3); // [R10]
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pulse = st_r.pulse;

    a_edge_polarity: assert property (@(posedge clk) disable iff (!rst_n) // [R10]
        (st_r.s2 != st_r.s3) |=> (pulse == ($past(rise_sel) == $past(st_r.s2))))
        else $error("pulse does not follow pin edge");
endmodule // drtp_pin_edge

// ===== core/drtp_pkg.sv
/*
 * Shared constants of the timer block.
 * Assumes a 32-bit AXI4-Lite bus with 8 address bits.
 */
package drtp_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PRESC = 8'h04;
    localparam logic [7:0] OFS_TA_LOAD = 8'h08;
    localparam logic [7:0] OFS_TA_HIGH = 8'h0c;
    localparam logic [7:0] OFS_TB_LOAD = 8'h10;
    localparam logic [7:0] OFS_TB_HIGH = 8'h14;
    localparam logic [7:0] OFS_COUNT = 8'h18;
    localparam logic [7:0] OFS_COPY = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_MASK = 8'h24;
    localparam logic [7:0] OFS_RELOADS = 8'h28;
    // Control register field positions.
    localparam int CB_PRESC_RUN = 0;
    localparam int CB_TA_RUN = 1;
    localparam int CB_TB_RUN = 2;
    localparam int CB_TA_PWM = 3;
    localparam int CB_TB_PWM = 4;
    localparam int CB_TA_SRC = 5;
    localparam int CB_TB_SRC = 7;
    localparam int CB_TA_RISE = 9;
    localparam int CB_TB_RISE = 10;
    localparam int CB_PIN0_OUT = 11;
    localparam int CB_PIN1_OUT = 12;
    localparam int CB_AUTO_GATE = 13;
    localparam int CTRL_W = 14;
    // Status and mask bit positions.
    localparam int SB_TA_UF = 0;
    localparam int SB_TB_UF = 1;
    // Reset values.
    localparam logic [13:0] CTRL_RST = 14'h0000;
    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Count source selection.
    typedef enum logic [1:0] {
        SRC_SYS = 2'b00,
        SRC_PRESC = 2'b01,
        SRC_PIN = 2'b10
    } drtp_src_type;
endpackage

// ===== core/drtp_timer.sv
/*
 * One 8-bit down counter with low and high reloads.
 * Assumes loads and copies happen while stopped.
 */
module drtp_timer (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Synchronised reset, active low.
    drtp_tmr_if.core t // Control and status.
);
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] low;
        logic [7:0] high;
        logic phase;
        logic uf;
    } drtp_tmr_type;
    drtp_tmr_type st_r;
    drtp_tmr_type st_nxt;

    // Count only on source events while running, never on start.
    always_comb begin
        st_nxt = st_r;
        st_nxt.uf = 1'b0;
        if (t.load_we) begin
            st_nxt.count = t.wdata; // [R5]
            st_nxt.low = t.wdata;
        end else if (t.copy) begin
            st_nxt.count = st_r.low; // [R5]
        end else if (t.run && t.src_pulse) begin // [R8]
            if (st_r.count == 8'h00) begin
                st_nxt.uf = 1'b1; // [R13]
                if (t.pwm_en) begin
                    // A stop on this edge still reloads; a known hazard. [R7]
                    st_nxt.phase = ~st_r.phase; // [R12]
                    st_nxt.count = st_r.phase ? st_r.low : st_r.high; // [R12]
                end else begin
                    st_nxt.phase = 1'b0;
                    st_nxt.count = st_r.low; // [R13]
                end
            end else begin
                st_nxt.count = st_r.count - 8'h01; // [R13]
            end
        end
        // Old high value feeds an underflow in this same cycle. [R6]
        if (t.high_we) begin
            st_nxt.high = t.wdata;
        end
        if (!t.pwm_en) begin
            st_nxt.phase = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign t.count = st_r.count;
    assign t.low_rl = st_r.low;
    assign t.high_rl = st_r.high;
    assign t.uf = st_r.uf;
    assign t.pwm = st_r.phase;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_hold_no_source: assert property ( // [R8]
        !(t.run && t.src_pulse) && !t.load_we && !t.copy |=> $stable(st_r.count))
        else $error("count moved without a source event");
    a_start_first_edge: assert property ( // [R9]
        $rose(t.run) && !t.src_pulse && !t.load_we && !t.copy ##1 !t.src_pulse && !t.load_we && !t.copy
        |=> st_r.count == $past(st_r.count, 2))
        else $error("count moved at start before first source edge");
    a_count_step: assert property ( // [R13]
        t.run && t.src_pulse && st_r.count != 8'h00 && !t.load_we && !t.copy
        |=> st_r.count == $past(st_r.count) - 8'h01 && !st_r.uf)
        else $error("count did not step down by one");
    a_uf_reload_low: assert property ( // [R13]
        t.run && t.src_pulse && st_r.count == 8'h00 && !t.pwm_en && !t.load_we && !t.copy
        |=> st_r.uf && st_r.count == $past(st_r.low))
        else $error("underflow did not flag and reload low value");
    a_pwm_alternate: assert property ( // [R12]
        t.run && t.src_pulse && st_r.count == 8'h00 && t.pwm_en && !t.load_we && !t.copy
        |=> st_r.phase != $past(st_r.phase)
        && st_r.count == ($past(st_r.phase) ? $past(st_r.low) : $past(st_r.high)))
        else $error("pulse mode did not alternate reloads");
    a_pwm_on_uf: assert property ( // [R7]
        $changed(st_r.phase) && $past(t.pwm_en) && t.pwm_en |-> st_r.uf)
        else $error("pulse level changed away from an underflow");
endmodule // drtp_timer

// ===== core/drtp_tmr_if.sv
/*
 * Carrier from the top level to one timer core.
 * Assumes one clock; strobes last one cycle.
 */
interface drtp_tmr_if;
    logic run; // Counting enabled.
    logic src_pulse; // One count-source event.
    logic pwm_en; // Alternate reload mode.
    logic load_we; // Write counter and low reload.
    logic high_we; // Write high reload.
    logic copy; // Copy low reload into counter.
    logic [7:0] wdata; // Data for the write strobes.
    logic [7:0] count; // Current count.
    logic [7:0] low_rl; // Low reload value.
    logic [7:0] high_rl; // High reload value.
    logic uf; // Underflow pulse.
    logic pwm; // Pulse level.
    modport ctl(output run, src_pulse, pwm_en, load_we, high_we, copy, wdata,
                input count, low_rl, high_rl, uf, pwm);
    modport core(input run, src_pulse, pwm_en, load_we, high_we, copy, wdata,
                 output count, low_rl, high_rl, uf, pwm);
endinterface

// ===== core/drtp_top.sv
/*
 * Prescaler, two reload timers, pin gating and an AXI4-Lite slave.
 * Assumes software stops a counter before touching it.
 */
// Our own choices: the address map and the AXI4-Lite register port.
// Behaviour
// R1: Prescaler is read only while halted.
// R2: Prescaler is written only while halted.
// R3: Timer stopped before its source changes.
// R4: Timer stopped before its count is read.
// R5: Timer stopped before counter load or copy.
// R6: High reload never written on an underflow cycle.
// R7: Stop on a pulse-mode underflow may glitch.
// R8: Counting starts at the first source edge.
// R9: First underflow may come one source period early.
// R10: Pin source counts the selected edge.
// R11: Auto gate toggles second output per timer A underflow.
// R12: Pulse mode reloads alternately low and high.
// R13: Divide by reload plus one; underflow flags and reloads.
module drtp_top
    import drtp_pkg::*;
(
    input wire logic clk, // Clock, 50 MHz.
    input wire logic resetn, // Async reset.
    input wire logic [7:0] s_axi_awaddr, // AW address.
    input wire logic s_axi_awvalid, // AW valid.
    output logic s_axi_awready, // AW ready.
    input wire logic [31:0] s_axi_wdata, // W data.
    input wire logic [3:0] s_axi_wstrb, // W strobes.
    input wire logic s_axi_wvalid, // W valid.
    output logic s_axi_wready, // W ready.
    output logic [1:0] s_axi_bresp, // B response.
    output logic s_axi_bvalid, // B valid.
    input wire logic s_axi_bready, // B ready.
    input wire logic [7:0] s_axi_araddr, // AR address.
    input wire logic s_axi_arvalid, // AR valid.
    output logic s_axi_arready, // AR ready.
    output logic [31:0] s_axi_rdata, // R data.
    output logic [1:0] s_axi_rresp, // R response.
    output logic s_axi_rvalid, // R valid.
    input wire logic s_axi_rready, // R ready.
    input wire logic counter_pin_zero_in, // Pin zero, timer B source.
    output logic counter_pin_zero_out, // Pin zero, first pulse.
    output logic counter_pin_zero_oe, // Pin zero enable.
    input wire logic counter_pin_one_in, // Pin one, timer A source.
    output logic counter_pin_one_out, // Pin one, second pulse.
    output logic counter_pin_one_oe, // Pin one enable.
    output logic irq // Level interrupt.
);
    import drtp_pkg::*;

    typedef struct packed {
        logic aw_rdy;
        logic w_rdy;
        logic aw_have;
        logic w_have;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [13:0] ctrl;
        logic [7:0] presc_rl;
        logic [7:0] presc_cnt;
        logic presc_tick;
        logic [1:0] status;
        logic [1:0] mask;
        logic gate;
        logic out0;
        logic oe0;
        logic out1;
        logic oe1;
        logic irq;
    } drtp_top_type;

    logic [1:0] rst_q_r;
    logic rst_n;
    drtp_top_type st_r;
    drtp_top_type st_nxt;
    logic pin0_pulse;
    logic pin1_pulse;
    logic wr_fire;
    logic [31:0] wmerged;
    drtp_tmr_if ta ();
    drtp_tmr_if tb ();

    // Merge write data under the byte enables.
    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Count event for a source selection.
    function automatic logic pick_source(input logic [1:0] sel, input logic presc_tick,
                                         input logic pin_pulse);
        logic res;
        res = 1'b0;
        if (sel == SRC_SYS) begin
            res = 1'b1;
        end else if (sel == SRC_PRESC) begin
            res = presc_tick;
        end else if (sel == SRC_PIN) begin
            res = pin_pulse;
        end
        return res;
    endfunction

    // Timer load, high reload and copy words, decoded for writes and reads.
    function automatic logic is_timer_ofs(input logic [7:0] a);
        return a == OFS_TA_LOAD || a == OFS_TA_HIGH || a == OFS_TB_LOAD || a == OFS_TB_HIGH || a == OFS_COPY;
    endfunction

    // Two-flop release so every flop leaves reset together.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_q_r <= 2'b00;
        end else begin
            rst_q_r <= {rst_q_r[0], 1'b1};
        end
    end
    assign rst_n = rst_q_r[1];

    // Pin one feeds timer A, pin zero feeds timer B.
    drtp_pin_edge u_edge0 (
        .clk(clk),
        .rst_n(rst_n),
        .pin(counter_pin_zero_in),
        .rise_sel(st_r.ctrl[CB_TB_RISE]),
        .pulse(pin0_pulse)
    );
    drtp_pin_edge u_edge1 (
        .clk(clk),
        .rst_n(rst_n),
        .pin(counter_pin_one_in),
        .rise_sel(st_r.ctrl[CB_TA_RISE]),
        .pulse(pin1_pulse)
    );

    drtp_timer u_ta (
        .clk(clk),
        .rst_n(rst_n),
        .t(ta.core)
    );
    drtp_timer u_tb (
        .clk(clk),
        .rst_n(rst_n),
        .t(tb.core)
    );

    // A write is performed once both address and data are held.
    assign wr_fire = st_r.aw_have && st_r.w_have && !st_r.bvalid;
    assign wmerged = merge_bytes(32'h0000_0000, st_r.wdata, st_r.wstrb);

    // Timer controls from control bits and write strobes.
    always_comb begin
        ta.run = st_r.ctrl[CB_TA_RUN];
        ta.pwm_en = st_r.ctrl[CB_TA_PWM];
        ta.src_pulse = pick_source(st_r.ctrl[CB_TA_SRC +: 2], st_r.presc_tick, pin1_pulse); // [R10]
        ta.load_we = wr_fire && st_r.awaddr == OFS_TA_LOAD && st_r.wstrb[0]; // [R5]
        ta.high_we = wr_fire && st_r.awaddr == OFS_TA_HIGH && st_r.wstrb[0]; // [R6]
        ta.copy = wr_fire && st_r.awaddr == OFS_COPY && st_r.wstrb[0] && st_r.wdata[0];
        ta.wdata = st_r.wdata[7:0];
        tb.run = st_r.ctrl[CB_TB_RUN];
        tb.pwm_en = st_r.ctrl[CB_TB_PWM];
        tb.src_pulse = pick_source(st_r.ctrl[CB_TB_SRC +: 2], st_r.presc_tick, pin0_pulse); // [R10]
        tb.load_we = wr_fire && st_r.awaddr == OFS_TB_LOAD && st_r.wstrb[0]; // [R5]
        tb.high_we = wr_fire && st_r.awaddr == OFS_TB_HIGH && st_r.wstrb[0]; // [R6]
        tb.copy = wr_fire && st_r.awaddr == OFS_COPY && st_r.wstrb[0] && st_r.wdata[1];
        tb.wdata = st_r.wdata[7:0];
    end

    // Next state: bus slave, registers, prescaler, flags, gating and pins.
    always_comb begin
        st_nxt = st_r;
        // Write address and data are taken independently, in either order.
        if (s_axi_awvalid && st_r.aw_rdy) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_r.w_rdy) begin
            st_nxt.w_have = 1'b1;
            st_nxt.wdata = s_axi_wdata;
            st_nxt.wstrb = s_axi_wstrb;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Prescaler starts from its loaded value.
        st_nxt.presc_tick = 1'b0;
        if (st_r.ctrl[CB_PRESC_RUN]) begin // [R8]
            if (st_r.presc_cnt == 8'h00) begin
                st_nxt.presc_tick = 1'b1;
                st_nxt.presc_cnt = st_r.presc_rl;
            end else begin
                st_nxt.presc_cnt = st_r.presc_cnt - 8'h01;
            end
        end

        // Underflows set sticky flags; a set wins over a clear in the same cycle.
        if (wr_fire) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OKAY;
            if (st_r.awaddr == OFS_CTRL) begin
                st_nxt.ctrl = CTRL_W'(merge_bytes({18'h00000, st_r.ctrl}, st_r.wdata, st_r.wstrb)); // [R3]
            end else if (st_r.awaddr == OFS_PRESC) begin
                if (st_r.wstrb[0]) begin
                    st_nxt.presc_rl = st_r.wdata[7:0]; // [R2]
                    st_nxt.presc_cnt = st_r.wdata[7:0];
                end
            end else if (st_r.awaddr == OFS_STATUS) begin
                st_nxt.status = st_r.status & ~wmerged[1:0];
            end else if (st_r.awaddr == OFS_MASK) begin
                st_nxt.mask = 2'(merge_bytes({30'h0000_0000, st_r.mask}, st_r.wdata, st_r.wstrb));
            end else if (is_timer_ofs(st_r.awaddr)) begin
                st_nxt.bresp = RESP_OKAY;
            end else begin
                st_nxt.bresp = RESP_SLVERR;
            end
        end
        if (ta.uf) begin
            st_nxt.status[SB_TA_UF] = 1'b1; // [R13]
        end
        if (tb.uf) begin
            st_nxt.status[SB_TB_UF] = 1'b1; // [R13]
        end
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);

        // Ready drops while a word or a response is held.
        st_nxt.aw_rdy = !st_nxt.aw_have && !st_nxt.bvalid;
        st_nxt.w_rdy = !st_nxt.w_have && !st_nxt.bvalid;

        // Reads return live counts; only a stopped counter reads stable.
        if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_r.ar_rdy) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            st_nxt.rdata = 32'h0000_0000;
            if (s_axi_araddr == OFS_CTRL) begin
                st_nxt.rdata = {18'h00000, st_r.ctrl};
            end else if (s_axi_araddr == OFS_PRESC) begin
                st_nxt.rdata = {16'h0000, st_r.presc_rl, st_r.presc_cnt}; // [R1]
            end else if (s_axi_araddr == OFS_COUNT) begin
                st_nxt.rdata = {16'h0000, tb.count, ta.count}; // [R4]
            end else if (s_axi_araddr == OFS_RELOADS) begin
                st_nxt.rdata = {tb.high_rl, tb.low_rl, ta.high_rl, ta.low_rl};
            end else if (s_axi_araddr == OFS_STATUS) begin
                st_nxt.rdata = {30'h0000_0000, st_r.status};
            end else if (s_axi_araddr == OFS_MASK) begin
                st_nxt.rdata = {30'h0000_0000, st_r.mask};
            end else if (is_timer_ofs(s_axi_araddr)) begin
                st_nxt.rresp = RESP_OKAY;
            end else begin
                st_nxt.rresp = RESP_SLVERR;
            end
        end
        st_nxt.ar_rdy = !st_nxt.rvalid;

        // A underflows toggle the gate; stopping A cancels it.
        if (!st_r.ctrl[CB_TA_RUN]) begin
            st_nxt.gate = 1'b0; // [R11]
        end else if (st_r.ctrl[CB_AUTO_GATE] && ta.uf) begin
            st_nxt.gate = ~st_r.gate; // [R11]
        end

        // Pins are registered so they never carry decode glitches.
        st_nxt.out0 = ta.pwm;
        st_nxt.oe0 = st_r.ctrl[CB_PIN0_OUT];
        st_nxt.out1 = tb.pwm & (~(st_r.ctrl[CB_AUTO_GATE] & st_r.ctrl[CB_TA_RUN]) | st_r.gate); // [R11]
        st_nxt.oe1 = st_r.ctrl[CB_PIN1_OUT];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs come straight from the state flops.
    assign s_axi_awready = st_r.aw_rdy;
    assign s_axi_wready = st_r.w_rdy;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = st_r.ar_rdy;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign counter_pin_zero_out = st_r.out0;
    assign counter_pin_zero_oe = st_r.oe0;
    assign counter_pin_one_out = st_r.out1;
    assign counter_pin_one_oe = st_r.oe1;
    assign irq = st_r.irq;

    a_gate_toggle: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        st_r.ctrl[CB_TA_RUN] && st_r.ctrl[CB_AUTO_GATE] && ta.uf |=> st_r.gate != $past(st_r.gate))
        else $error("gate missed an underflow");
    a_gate_cancel: assert property (@(posedge clk) disable iff (!rst_n) // [R11]
        !st_r.ctrl[CB_TA_RUN] |=> !st_r.gate ##1 (st_r.out1 == $past(tb.pwm) || $past(st_r.ctrl[CB_TA_RUN])))
        else $error("stopped timer A still gates");
    a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n) // [R13]
        ta.uf |=> st_r.status[SB_TA_UF] ##1 (irq || !$past(st_r.mask[SB_TA_UF])))
        else $error("underflow flag or interrupt missing");
    a_presc_wait: assert property (@(posedge clk) disable iff (!rst_n) // [R8]
        $rose(st_r.ctrl[CB_PRESC_RUN]) && st_r.presc_cnt != 8'h00 |-> !st_r.presc_tick ##1 !st_r.presc_tick)
        else $error("prescaler ticked early");
endmodule // drtp_top

// ===== tb/drtp_cpu_model.sv
/*
 * AXI4-Lite master standing in for the processor.
 * Assumes the caller waits for reset release.
 */
module drtp_cpu_model (
    input wire logic clk, // System clock.
    output logic [7:0] s_axi_awaddr, // AW address.
    output logic s_axi_awvalid, // AW valid.
    input wire logic s_axi_awready, // AW ready.
    output logic [31:0] s_axi_wdata, // W data.
    output logic [3:0] s_axi_wstrb, // W strobes.
    output logic s_axi_wvalid, // W valid.
    input wire logic s_axi_wready, // W ready.
    input wire logic [1:0] s_axi_bresp, // B response.
    input wire logic s_axi_bvalid, // B valid.
    output logic s_axi_bready, // B ready.
    output logic [7:0] s_axi_araddr, // AR address.
    output logic s_axi_arvalid, // AR valid.
    input wire logic s_axi_arready, // AR ready.
    input wire logic [31:0] s_axi_rdata, // R data.
    input wire logic [1:0] s_axi_rresp, // R response.
    input wire logic s_axi_rvalid, // R valid.
    output logic s_axi_rready // R ready.
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus during reset.
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end
    // Write; ok stays low if no answer came.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, output bit ok);
        ok = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 64 && !ok; i++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                ok = 1;
                s_axi_bready <= 1'b0;
            end
        end
    endtask
    // Read, same scheme.
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, output bit ok);
        ok = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 64 && !ok; i++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                ok = 1;
                s_axi_rready <= 1'b0;
            end
        end
    endtask
endmodule // drtp_cpu_model

// ===== tb/dual_reload_timer_pwm_tb.sv
/*
 * Bench for the timer block.
 * Assumes the CPU model drives the bus.
 */
module dual_reload_timer_pwm_tb import drtp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
    logic counter_pin_zero_in = 1'b0, counter_pin_one_in = 1'b0;
    logic counter_pin_zero_out, counter_pin_zero_oe, counter_pin_one_out, counter_pin_one_oe;
    int err_total = 0, total_checks = 0;
    int n, lo, hi;
    bit ok;
    drtp_top u_dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .counter_pin_zero_in, .counter_pin_zero_out, .counter_pin_zero_oe,
        .counter_pin_one_in, .counter_pin_one_out, .counter_pin_one_oe, .irq);
    drtp_cpu_model u_cpu (.clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    // Free-running 50 MHz clock.
    always #10 clk = ~clk;
    // Checks, verdict and bus wrappers.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic hang(input bit good);
        if (!good) begin
            err_total++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        u_cpu.wr(a, d, rr, ok);
        hang(ok);
        chk(32'(rr), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
        u_cpu.rd(a, d, rr, ok);
        hang(ok);
        chk(32'(rr), 32'(er));
    endtask
    // Cycles of one level on the first pulse output.
    task automatic len(input logic lvl, output int k);
        k = 1;
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            if (counter_pin_zero_out !== lvl) return;
            k++;
        end
        hang(0);
    endtask
    // High samples of the second output.
    task automatic hi_cnt(input int c, output int k);
        k = 0;
        repeat (c) begin
            @(posedge clk);
            if (counter_pin_one_out === 1'b1) k++;
        end
    endtask
    task automatic pin0(input logic v);
        @(posedge clk);
        counter_pin_zero_in <= v;
        repeat (8) @(posedge clk);
    endtask
    task automatic t_regs();
        rd(OFS_CTRL, RESP_OKAY, rv);
        chk(rv, 32'(CTRL_RST));
        rd(8'h40, RESP_SLVERR, rv);
        wr(8'h40, 32'h0000_00ff, RESP_SLVERR);
        wr(OFS_PRESC, 32'h0000_0005, RESP_OKAY);
        rd(OFS_PRESC, RESP_OKAY, rv);
        chk(rv, 32'h0000_0505);
        wr(OFS_TA_LOAD, 32'h0000_0007, RESP_OKAY);
        rd(OFS_COUNT, RESP_OKAY, rv);
        chk(rv, 32'h0000_0007);
    endtask
    // Pulse mode on timer A: low 3, high 5 cycles; then flags.
    task automatic t_pwm();
        wr(OFS_MASK, 32'h0000_0001, RESP_OKAY);
        wr(OFS_TA_LOAD, 32'h0000_0002, RESP_OKAY);
        wr(OFS_TA_HIGH, 32'h0000_0004, RESP_OKAY);
        wr(OFS_CTRL, 32'h0000_080a, RESP_OKAY);
        len(0, n);
        len(1, n);
        len(0, lo);
        len(1, hi);
        chk(32'(lo), 32'h3);
        chk(32'(hi), 32'h5);
        chk(32'(irq), 32'h1);
        wr(OFS_CTRL, 32'h0, RESP_OKAY);
        wr(OFS_MASK, 32'h0, RESP_OKAY);
        rd(OFS_STATUS, RESP_OKAY, rv);
        chk(rv, 32'h1);
        chk(32'(irq), 32'h0);
        wr(OFS_STATUS, 32'h1, RESP_OKAY);
        rd(OFS_STATUS, RESP_OKAY, rv);
        chk(rv, 32'h0);
    endtask
    // Timer B counts rising pin zero edges.
    task automatic t_pin();
        wr(OFS_TB_LOAD, 32'h0000_0001, RESP_OKAY);
        wr(OFS_CTRL, 32'h0000_0504, RESP_OKAY);
        pin0(1'b1);
        pin0(1'b0);
        rd(OFS_STATUS, RESP_OKAY, rv);
        chk(rv, 32'h0);
        pin0(1'b1);
        rd(OFS_STATUS, RESP_OKAY, rv);
        chk(rv, 32'h2);
        wr(OFS_CTRL, 32'h0, RESP_OKAY);
        wr(OFS_STATUS, 32'h2, RESP_OKAY);
    endtask
    // Timer A underflows gate the pulse of timer B.
    task automatic t_gate();
        wr(OFS_TA_LOAD, 32'h0000_0028, RESP_OKAY);
        wr(OFS_TB_LOAD, 32'h0000_0001, RESP_OKAY);
        wr(OFS_TB_HIGH, 32'h0000_0001, RESP_OKAY);
        wr(OFS_CTRL, 32'h0000_3016, RESP_OKAY);
        hi_cnt(30, n);
        chk(32'(n), 32'h0);
        hi_cnt(18, n);
        hi_cnt(25, n);
        chk(32'(n > 0), 32'h1);
        hi_cnt(15, n);
        hi_cnt(25, n);
        chk(32'(n), 32'h0);
        wr(OFS_CTRL, 32'h0000_3014, RESP_OKAY);
        hi_cnt(20, n);
        chk(32'(n > 0), 32'h1);
    endtask
    // Reset, then the scenarios.
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_pwm();
        t_pin();
        t_gate();
        stop_test();
    end
endmodule // dual_reload_timer_pwm_tb
